// [ebuf_out_pkg.sv]
// Constants for the outbound extended-buffer channel transfer block
package ebuf_out_pkg;
   // AXI4-Lite register byte offsets
   localparam logic [7:0] ADR_MODE = 8'h00;
   localparam logic [7:0] ADR_LOAD = 8'h04;
   localparam logic [7:0] ADR_XADR = 8'h08;
   localparam logic [7:0] ADR_CSAD = 8'h0C;
   localparam logic [7:0] ADR_START = 8'h10;
   localparam logic [7:0] ADR_PINT = 8'h14;
   localparam logic [7:0] ADR_ISRC = 8'h18;
   localparam logic [7:0] ADR_SEL = 8'h1C;
   localparam logic [7:0] ADR_ISTAT = 8'h20;
   localparam logic [7:0] ADR_STAT = 8'h24;
   localparam logic [7:0] ADR_CFG = 8'h28;
   // Outbus bit n.m sits at bit (15-8n-m) of the halfword
   localparam int B00 = 15;
   localparam int B06 = 9;
   localparam int B11 = 6;
   localparam int B15 = 2;
   localparam int B17 = 0;
   localparam int ISRC_L3 = 7;
   localparam int ISRC_INIT = 3;
   localparam int ISRC_ADAP = 1;
   localparam logic [7:0] ISTAT_NORMAL = 8'h80;
   localparam logic [7:0] ISTAT_BUSY = 8'h70;
   localparam logic [5:0] MAX_BYTES = 6'h20;
   // Burst jumper codes
   localparam logic [1:0] BURST_4 = 2'h0;
   localparam logic [1:0] BURST_8 = 2'h1;
   localparam logic [1:0] BURST_16 = 2'h2;
   localparam logic [1:0] BURST_32 = 2'h3;
   localparam int CLK_MHZ = 125;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int DLY_MACH_CYC = 32;
   localparam int MACH_NS = 8;
   localparam logic [7:0] DLY_CYC = 8'((DLY_MACH_CYC * MACH_NS) / CLK_NS);
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : ebuf_out_pkg

// [ebuf_out.sv]
// Outbound extended-buffer transfer adapter with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ebuf_out (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] burst_jmp_i,
   input wire logic [7:0] sel_addr_i,
   input wire logic [7:0] sel_cmd_i,
   input wire logic init_sel_i,
   input wire logic service_out_i,
   output logic request_in_o,
   output logic op_in_o,
   output logic service_in_o,
   output logic [7:0] bus_in_o,
   output logic busy_status_o
);
   // ****************************
   // State
   // ****************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_REQ = 5'b00010,
      ST_SVC = 5'b00100,
      ST_WAIT = 5'b01000,
      ST_DLY = 5'b10000
   } ch_state_e;

   logic [7:0] mem_ff [0:31];
   ch_state_e st_ff, nxt_st;
   logic [4:0] cnt_ff, nxt_cnt, bcnt_ff, nxt_bcnt, mem_wa;
   logic [7:0] xadr_ff, nxt_xadr, dly_ff, nxt_dly, ld1_ff, nxt_ld1;
   logic [7:0] bus_ff, nxt_bus, awa_ff, nxt_awa, mem_wd;
   logic [15:0] csad_ff, nxt_csad;
   logic [1:0] xbyte_ff, nxt_xbyte, br_ff, nxt_br, rr_ff, nxt_rr;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic ebuf_ff, nxt_ebuf, odd_ff, nxt_odd, init_ff, nxt_init;
   logic prio_ff, nxt_prio, dsint_ff, nxt_dsint, pint_ff, nxt_pint;
   logic isint_ff, nxt_isint, dlyl_ff, nxt_dlyl, ld_ff, nxt_ld;
   logic req_ff, nxt_req, op_ff, nxt_op, svc_ff, nxt_svc;
   logic busy_ff, nxt_busy, rv_ff, nxt_rv, ar_ff, nxt_ar;
   logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv;
   logic do_wr, mem_we;

   function automatic logic burst_end(input logic [1:0] j,
                                      input logic [4:0] c);
      case (j)
         ebuf_out_pkg::BURST_4: burst_end = (c[1:0] == 2'h0);
         ebuf_out_pkg::BURST_8: burst_end = (c[2:0] == 3'h0);
         ebuf_out_pkg::BURST_16: burst_end = (c[3:0] == 4'h0);
         default: burst_end = 1'b0;
      endcase
   endfunction : burst_end

   // ****************************
   // Bus and register logic
   // ****************************
   always_comb begin
      nxt_awr = awr_ff;
      nxt_wr = wr_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_bv = bv_ff;
      nxt_br = br_ff;
      nxt_rv = rv_ff;
      nxt_rr = rr_ff;
      nxt_rd = rd_ff;
      nxt_ar = 1'b0;
      nxt_ebuf = ebuf_ff;
      nxt_bcnt = bcnt_ff;
      nxt_xadr = xadr_ff;
      nxt_csad = csad_ff;
      nxt_xbyte = xbyte_ff;
      nxt_odd = odd_ff;
      nxt_prio = prio_ff;
      nxt_dsint = dsint_ff;
      nxt_pint = pint_ff;
      nxt_isint = isint_ff;
      nxt_ld = 1'b0;
      nxt_ld1 = ld1_ff;
      mem_we = 1'b0;
      mem_wa = cnt_ff;
      mem_wd = 8'h00;
      do_wr = 1'b0;
      if (s_axi_awvalid && !awr_ff && !bv_ff) begin
         nxt_awr = 1'b1;
         nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wr_ff && !bv_ff) begin
         nxt_wr = 1'b1;
         nxt_wd = s_axi_wdata;
      end
      if (awr_ff && wr_ff && !bv_ff && !ld_ff) begin
         do_wr = 1'b1;
         nxt_awr = 1'b0;
         nxt_wr = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = ebuf_out_pkg::RESP_OK;
         case (awa_ff)
            ebuf_out_pkg::ADR_MODE: begin
               nxt_ebuf = wd_ff[ebuf_out_pkg::B00];
               nxt_bcnt = wd_ff[4:0];
            end
            ebuf_out_pkg::ADR_LOAD: begin
               mem_we = 1'b1;
               mem_wd = wd_ff[15:8];
               nxt_ld = 1'b1;
               nxt_ld1 = wd_ff[7:0];
            end
            ebuf_out_pkg::ADR_XADR: nxt_xadr = wd_ff[15:8];
            ebuf_out_pkg::ADR_CSAD: begin
               nxt_csad = wd_ff[15:0];
               nxt_xbyte = 2'h0;
               nxt_odd = wd_ff[ebuf_out_pkg::B17];
            end
            ebuf_out_pkg::ADR_START: begin
               if (wd_ff[ebuf_out_pkg::B06]) nxt_dsint = 1'b0;
               if (wd_ff[ebuf_out_pkg::B15]) nxt_prio = 1'b1;
            end
            ebuf_out_pkg::ADR_PINT:
               if (wd_ff[ebuf_out_pkg::B11]) nxt_pint = 1'b1;
            default: nxt_br = ebuf_out_pkg::RESP_ERR;
         endcase
      end
      if (ld_ff) begin
         mem_we = 1'b1;
         mem_wd = ld1_ff;
      end
      if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
      if (init_sel_i && !pint_ff) nxt_isint = 1'b1;
      if (st_ff == ST_SVC && cnt_ff == bcnt_ff) nxt_dsint = 1'b1;
      if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
      if (!rv_ff && s_axi_arvalid) begin
         nxt_rv = 1'b1;
         nxt_ar = 1'b1;
         nxt_rr = ebuf_out_pkg::RESP_OK;
         nxt_rd = 32'h0000_0000;
         case (s_axi_araddr)
            ebuf_out_pkg::ADR_ISRC: begin
               nxt_rd[ebuf_out_pkg::ISRC_L3] = isint_ff | dsint_ff;
               nxt_rd[ebuf_out_pkg::ISRC_INIT] = isint_ff;
               nxt_rd[ebuf_out_pkg::ISRC_ADAP] = 1'b0;
            end
            ebuf_out_pkg::ADR_SEL:
               nxt_rd[15:0] = {sel_addr_i, sel_cmd_i};
            ebuf_out_pkg::ADR_ISTAT:
               nxt_rd[15:8] = (st_ff == ST_DLY) ? ebuf_out_pkg::ISTAT_BUSY
                  : ebuf_out_pkg::ISTAT_NORMAL;
            ebuf_out_pkg::ADR_XADR: nxt_rd[15:0] = {xadr_ff, 8'h00};
            ebuf_out_pkg::ADR_CSAD: nxt_rd[15:0] = csad_ff;
            ebuf_out_pkg::ADR_MODE:
               nxt_rd[15:0] = {ebuf_ff, 10'h000, bcnt_ff};
            ebuf_out_pkg::ADR_STAT:
               nxt_rd[15:0] = {4'h0, st_ff, init_ff, prio_ff, odd_ff,
                               xbyte_ff, dlyl_ff, pint_ff};
            default: nxt_rr = ebuf_out_pkg::RESP_ERR;
         endcase
      end
   end

   // ****************************
   // Channel sequencer
   // ****************************
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_init = init_ff;
      nxt_dlyl = dlyl_ff;
      nxt_dly = dly_ff;
      nxt_req = req_ff;
      nxt_op = op_ff;
      nxt_svc = 1'b0;
      nxt_bus = bus_ff;
      nxt_busy = 1'b0;
      if (do_wr && awa_ff == ebuf_out_pkg::ADR_MODE)
         nxt_cnt = 5'h00;
      if (mem_we) nxt_cnt = cnt_ff + 5'h01;
      if (do_wr && awa_ff == ebuf_out_pkg::ADR_START
          && wd_ff[ebuf_out_pkg::B00]) begin
         nxt_init = 1'b1;
         nxt_cnt = 5'h00;
      end
      case (st_ff)
         ST_IDLE:
            if (init_ff && ebuf_ff) begin
               nxt_st = ST_REQ;
               nxt_req = 1'b1;
            end
         ST_REQ: begin
            nxt_req = 1'b0;
            nxt_op = 1'b1;
            nxt_st = ST_SVC;
         end
         ST_SVC: begin
            if (cnt_ff == bcnt_ff && cnt_ff != 5'h00) begin
               nxt_init = 1'b0;
               nxt_op = 1'b0;
               nxt_st = ST_IDLE;
            end else begin
               nxt_bus = mem_ff[cnt_ff];
               nxt_svc = 1'b1;
               nxt_st = ST_WAIT;
            end
         end
         ST_WAIT:
            if (service_out_i) begin
               nxt_cnt = cnt_ff + 5'h01;
               if (burst_end(burst_jmp_i, nxt_cnt)
                   && nxt_cnt != bcnt_ff) begin
                  nxt_dlyl = 1'b1;
                  nxt_op = 1'b0;
                  nxt_dly = ebuf_out_pkg::DLY_CYC;
                  nxt_st = ST_DLY;
               end else begin
                  nxt_st = ST_SVC;
               end
            end
         ST_DLY: begin
            nxt_busy = 1'b1;
            nxt_dly = dly_ff - 8'h01;
            if (dly_ff == 8'h01) begin
               nxt_dlyl = 1'b0;
               nxt_req = 1'b1;
               nxt_st = ST_REQ;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (mem_we) mem_ff[mem_wa] <= mem_wd;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 5'h00;
         bcnt_ff <= 5'h00;
         ebuf_ff <= 1'b0;
         xadr_ff <= 8'h00;
         csad_ff <= 16'h0000;
         xbyte_ff <= 2'h0;
         odd_ff <= 1'b0;
         init_ff <= 1'b0;
         prio_ff <= 1'b0;
         dsint_ff <= 1'b0;
         pint_ff <= 1'b0;
         isint_ff <= 1'b0;
         dlyl_ff <= 1'b0;
         dly_ff <= 8'h00;
         ld_ff <= 1'b0;
         ld1_ff <= 8'h00;
         req_ff <= 1'b0;
         op_ff <= 1'b0;
         svc_ff <= 1'b0;
         bus_ff <= 8'h00;
         busy_ff <= 1'b0;
         awr_ff <= 1'b0;
         wr_ff <= 1'b0;
         awa_ff <= 8'h00;
         wd_ff <= 32'h0000_0000;
         bv_ff <= 1'b0;
         br_ff <= 2'h0;
         rv_ff <= 1'b0;
         ar_ff <= 1'b0;
         rr_ff <= 2'h0;
         rd_ff <= 32'h0000_0000;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         bcnt_ff <= nxt_bcnt;
         ebuf_ff <= nxt_ebuf;
         xadr_ff <= nxt_xadr;
         csad_ff <= nxt_csad;
         xbyte_ff <= nxt_xbyte;
         odd_ff <= nxt_odd;
         init_ff <= nxt_init;
         prio_ff <= nxt_prio;
         dsint_ff <= nxt_dsint;
         pint_ff <= nxt_pint;
         isint_ff <= nxt_isint;
         dlyl_ff <= nxt_dlyl;
         dly_ff <= nxt_dly;
         ld_ff <= nxt_ld;
         ld1_ff <= nxt_ld1;
         req_ff <= nxt_req;
         op_ff <= nxt_op;
         svc_ff <= nxt_svc;
         bus_ff <= nxt_bus;
         busy_ff <= nxt_busy;
         awr_ff <= nxt_awr;
         wr_ff <= nxt_wr;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         rv_ff <= nxt_rv;
         ar_ff <= nxt_ar;
         rr_ff <= nxt_rr;
         rd_ff <= nxt_rd;
      end
   end

   assign s_axi_awready = awr_ff;
   assign s_axi_wready = wr_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = ar_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rresp = rr_ff;
   assign s_axi_rdata = rd_ff;
   assign request_in_o = req_ff;
   assign op_in_o = op_ff;
   assign service_in_o = svc_ff;
   assign bus_in_o = bus_ff;
   assign busy_status_o = busy_ff;

   // ****************************
   // Assertions
   // ****************************
   AST_MODE_CLR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      do_wr && awa_ff == ebuf_out_pkg::ADR_MODE && st_ff == ST_IDLE
      |=> cnt_ff == 5'h00)
      else $error("Mode write did not clear counter");
   AST_LOAD_STEP: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      do_wr && awa_ff == ebuf_out_pkg::ADR_LOAD && st_ff == ST_IDLE
      |=> ld_ff ##1 cnt_ff == $past(cnt_ff, 2) + 5'h02)
      else $error("Load did not step counter twice");
   AST_LOAD_DATA: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      mem_we |=> mem_ff[$past(mem_wa)] == $past(mem_wd))
      else $error("Local store byte not written");
   AST_START_REQ: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      st_ff == ST_IDLE && init_ff && ebuf_ff |=> request_in_o)
      else $error("Request In not raised after start");
   AST_SVC_BYTE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      nxt_svc |=> service_in_o && bus_in_o == mem_ff[$past(cnt_ff)])
      else $error("Service In byte mismatch");
   AST_DLY_OP: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      st_ff == ST_DLY |-> !op_in_o && dlyl_ff)
      else $error("Op In up during delay");
   AST_BUSY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      st_ff == ST_DLY ##1 st_ff == ST_DLY |-> busy_status_o)
      else $error("Busy not shown during delay");
   AST_END: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      st_ff == ST_SVC && cnt_ff == bcnt_ff && cnt_ff != 5'h00
      |=> !init_ff && st_ff == ST_IDLE)
      else $error("Service not ended at count");
   AST_NO32: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      burst_jmp_i == ebuf_out_pkg::BURST_32 && st_ff == ST_WAIT
      |=> st_ff != ST_DLY)
      else $error("Delay entered for 32-byte burst");
   COV_DLY: cover property (@(posedge clk_sys_i) st_ff == ST_DLY);
   COV_END: cover property (@(posedge clk_sys_i)
      st_ff == ST_SVC && cnt_ff == bcnt_ff && cnt_ff != 5'h00);
   COV_LOAD: cover property (@(posedge clk_sys_i) ld_ff);
endmodule : ebuf_out

// [chan_model.sv]
// Host channel side model answering each byte with Service Out
`timescale 1ns/1ps
module chan_model (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic service_in_i,
   input wire logic [3:0] dly_i,
   output logic service_out_o
);
   logic [3:0] cnt_ff;
   logic busy_ff;
   // ***************************************
   // Byte handshake
   // ***************************************
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         busy_ff <= 1'b0;
         cnt_ff <= 4'h0;
         service_out_o <= 1'b0;
      end else begin
         service_out_o <= 1'b0;
         if (service_in_i) begin
            busy_ff <= 1'b1;
            cnt_ff <= dly_i;
         end else if (busy_ff) begin
            if (cnt_ff == 4'h0) begin
               service_out_o <= 1'b1;
               busy_ff <= 1'b0;
            end else begin
               cnt_ff <= cnt_ff - 4'h1;
            end
         end
      end
   end
endmodule : chan_model

// [tb_top.sv]
// Testbench for the outbound buffered channel adapter
`timescale 1ns/1ps
module tb_top;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, sel_addr = 8'h5A;
   logic [7:0] sel_cmd = 8'h02, bus_in;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, jmp = 2'h0;
   logic init_sel = 1'b0, svc_out, req_in, op_in, svc_in, busy;
   logic [3:0] svc_dly = 4'h0;
   logic [7:0] rx [0:31];
   int num_errors = 0, n_checks = 0, nrx = 0, nreq = 0, cyc = 0;
   int t_fall = 0, gap = 0;
   logic op_q = 1'b0;
   logic [31:0] d;
   logic [1:0] r;
   always #4 clk_sys_i = ~clk_sys_i;
   ebuf_out uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .burst_jmp_i(jmp),
      .sel_addr_i(sel_addr), .sel_cmd_i(sel_cmd), .init_sel_i(init_sel),
      .service_out_i(svc_out), .request_in_o(req_in), .op_in_o(op_in),
      .service_in_o(svc_in), .bus_in_o(bus_in), .busy_status_o(busy));
   chan_model chan (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .service_in_i(svc_in), .dly_i(svc_dly), .service_out_o(svc_out));
   // ***************************************
   // Channel monitor
   // ***************************************
   always @(posedge clk_sys_i) begin
      cyc++;
      if (op_q && !op_in) t_fall = cyc;
      if (req_in) begin
         nreq++;
         gap = cyc - t_fall;
      end
      if (svc_in && nrx < 32) begin
         rx[nrx] = bus_in;
         nrx++;
      end
      op_q = op_in;
   end
   // ***************************************
   // Tasks
   // ***************************************
   task summarize;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [15:0] v);
      logic aw, w, done;
      int n;
      aw = 1'b1;
      w = 1'b1;
      done = 1'b0;
      n = 0;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 200) begin
         @(posedge clk_sys_i);
         n++;
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            done = 1'b1;
            r = bresp;
         end
      end
      bready <= 1'b0;
      if (!done) chk(32'h0, 32'h1);
   endtask : wr
   task rd(input logic [7:0] a);
      logic ar, done;
      int n;
      ar = 1'b1;
      done = 1'b0;
      n = 0;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && n < 200) begin
         @(posedge clk_sys_i);
         n++;
         if (ar && arready) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            done = 1'b1;
            d = rdata;
            r = rresp;
         end
      end
      if (ar) arvalid <= 1'b0;
      rready <= 1'b0;
      if (!done || ar) chk(32'h0, 32'h1);
   endtask : rd
   task xfer(input logic [1:0] j, input int cnt, input int nexp);
      int n;
      logic [15:0] hw;
      jmp <= j;
      nrx = 0;
      nreq = 0;
      wr(ebuf_out_pkg::ADR_MODE, 16'h8000 | 16'(cnt));
      for (int i = 0; i < (cnt + 1) / 2; i++) begin
         hw = 16'(32'h4041 + 32'h0202 * i);
         wr(ebuf_out_pkg::ADR_LOAD, hw);
      end
      wr(ebuf_out_pkg::ADR_START, 16'h8204);
      if (j == ebuf_out_pkg::BURST_4) begin
         n = 0;
         while (!busy && n < 500) begin
            @(posedge clk_sys_i);
            n++;
         end
         rd(ebuf_out_pkg::ADR_ISTAT);
         chk(d & 32'h0000FF00,
            {16'h0, ebuf_out_pkg::ISTAT_BUSY, 8'h00});
      end
      n = 0;
      while ((nrx < cnt || op_in) && n < 3000) begin
         @(posedge clk_sys_i);
         n++;
      end
      repeat (60) @(posedge clk_sys_i);
      chk(32'(nrx), 32'(cnt));
      for (int i = 0; i < cnt; i++) begin
         chk({24'h0, rx[i]}, 32'h40 + 32'(i));
      end
      chk(32'(nreq), 32'(nexp));
      rd(ebuf_out_pkg::ADR_STAT);
      chk(d & 32'h00000060, 32'h00000020);
      if (nexp > 1) begin
         n_checks++;
         if (gap < int'(ebuf_out_pkg::DLY_CYC) ||
             gap > int'(ebuf_out_pkg::DLY_CYC) + 4) begin
            num_errors++;
            $display("[FAIL] t=%0t gap=%h dly=%h", $time, gap,
               ebuf_out_pkg::DLY_CYC);
         end
      end
   endtask : xfer
   // ***************************************
   // Watchdog
   // ***************************************
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      num_errors++;
      summarize();
   end
   // ***************************************
   // Tests
   // ***************************************
   initial begin
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      init_sel <= 1'b1;
      @(posedge clk_sys_i);
      init_sel <= 1'b0;
      rd(ebuf_out_pkg::ADR_ISRC);
      chk(d & 32'h0000008A, 32'h00000088);
      rd(ebuf_out_pkg::ADR_SEL);
      chk(d, 32'h00005A02);
      rd(ebuf_out_pkg::ADR_ISTAT);
      chk(d, 32'h00008000);
      wr(ebuf_out_pkg::ADR_XADR, 16'hA5FF);
      rd(ebuf_out_pkg::ADR_XADR);
      chk(d, 32'h0000A500);
      wr(ebuf_out_pkg::ADR_CSAD, 16'h1235);
      rd(ebuf_out_pkg::ADR_CSAD);
      chk(d, 32'h00001235);
      rd(ebuf_out_pkg::ADR_STAT);
      chk(d & 32'h0000001C, 32'h00000010);
      rd(8'h3C);
      chk({30'h0, r}, {30'h0, ebuf_out_pkg::RESP_ERR});
      wr(8'h3C, 16'h1111);
      chk({30'h0, r}, {30'h0, ebuf_out_pkg::RESP_ERR});
      xfer(ebuf_out_pkg::BURST_4, 7, 2);
      xfer(ebuf_out_pkg::BURST_8, 20, 3);
      svc_dly <= 4'h5;
      xfer(ebuf_out_pkg::BURST_16, 20, 2);
      svc_dly <= 4'h0;
      xfer(ebuf_out_pkg::BURST_32, 20, 1);
      nrst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      wr(ebuf_out_pkg::ADR_PINT, 16'h0040);
      init_sel <= 1'b1;
      @(posedge clk_sys_i);
      init_sel <= 1'b0;
      rd(ebuf_out_pkg::ADR_ISRC);
      chk(d & 32'h00000008, 32'h00000000);
      summarize();
   end
endmodule : tb_top
